/* File: verilog/gbipc_pkg.sv */
// constants shared by the pin bank controller and its edge detector
// assumes a register port with a 16-bit address and 16-bit data
package gbipc_pkg;

    // ------------------------------------------------------------
    // bank geometry
    // ------------------------------------------------------------
    localparam int GBIPC_NPINS = 32;
    localparam int GBIPC_HALF = 16;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_RISE_EN_LO = 16'h03ca;
    localparam logic [15:0] OFS_FALL_EN_LO = 16'h03cb;
    localparam logic [15:0] OFS_DIR_HI = 16'h03cd;
    localparam logic [15:0] OFS_DRV_HIGH_HI = 16'h03ce;
    localparam logic [15:0] OFS_DRV_LOW_HI = 16'h03cf;
    localparam logic [15:0] OFS_LEVEL_HI = 16'h03d0;
    localparam logic [15:0] OFS_HIZ_HI = 16'h03d1;
    localparam logic [15:0] OFS_DRAIN_HI = 16'h03d2;
    localparam logic [15:0] OFS_PULLUP_HI = 16'h03d3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_RISE_EN = 16'hffff;
    localparam logic [15:0] RST_FALL_EN = 16'hffff;
    localparam logic [15:0] RST_DIR = 16'h0000;
    localparam logic [15:0] RST_LEVEL = 16'h0000;
    localparam logic [15:0] RST_HIZ = 16'h0000;
    localparam logic [15:0] RST_DRAIN = 16'h0000;
    localparam logic [15:0] RST_PULLUP = 16'hffff;
    localparam logic [15:0] RD_NONE = 16'h0000;

    // ------------------------------------------------------------
    // timing: edges after reset before edge detection is trusted
    // ------------------------------------------------------------
    localparam logic [1:0] ARM_CYCLES = 2'h3;

    function automatic logic gbipc_hit(input logic [15:0] addr, input logic [15:0] ofs);
        return addr == ofs;
    endfunction

endpackage

/* File: verilog/gbipc_edge_if.sv */
// bundle carrying synchronised pin levels and edge strobes
// assumes one producer (edge detector) and one consumer (bank control)
`timescale 1ns/1ns
interface gbipc_edge_if #(parameter int W = 32);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src(output level, output rise, output fall);
    modport snk(input level, input rise, input fall);
endinterface

/* File: verilog/gbipc_edge_detect.sv */
// two-flop synchroniser and edge detector for every pin of the bank
// assumes clk_i and a synchronous active-high reset
`timescale 1ns/1ns
module gbipc_edge_detect
    import gbipc_pkg::*;
#(
    parameter int W = GBIPC_NPINS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    gbipc_edge_if.src edge_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;
    logic [1:0] arm_r;
    logic armed;

    if (W < 1) begin : g_width_check
        $error("gbipc_edge_detect: W must be at least 1");
    end

    // ------------------------------------------------------------
    // synchroniser: meta_r is read only by sync_r
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // hold off detection until the pipeline holds real samples, so a pin
    // that sits high through reset does not fake a rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm_r <= '0;
        end else if (arm_r != ARM_CYCLES) begin
            arm_r <= arm_r + 2'h1;
        end
    end

    assign armed = (arm_r == ARM_CYCLES);
    assign edge_o.level = sync_r;
    assign edge_o.rise = armed ? (sync_r & ~prev_r) : '0;
    assign edge_o.fall = armed ? (~sync_r & prev_r) : '0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_edge_single;
        @(posedge clk_i) disable iff (rst_i)
        ((edge_o.rise | edge_o.fall) != '0) |=> ((edge_o.rise & $past(edge_o.rise)) == '0)
            && ((edge_o.fall & $past(edge_o.fall)) == '0);
    endproperty
    a_edge_single: assert property (p_edge_single)
        else $error("edge strobe held for two cycles");

endmodule // gbipc_edge_detect

/* File: verilog/gbipc_top.sv */
// pin bank control: edge interrupt enables for the low bank and
// direction, drive, level, high-impedance, drain and pull-up for the high bank
// assumes a single-cycle register port, pins sampled on clk_i
//
// What this block does
// - rising edge on unmasked low input pin sets its interrupt when enabled
// - falling edge on unmasked low input pin sets its interrupt when enabled
// - both enables set: every transition of that pin raises an interrupt
// - edge enables of output pins do nothing; outputs never interrupt
// - high bank direction bit: clear is input, set is output; resets clear
// - writing one to drive-high register drives that output pin high
// - writing one to drive-low register drives that output pin low
// - level register write drives output pins; input pin bits are ignored
// - level register read returns present state of every owned pin
// - outputs changed by one write may switch at slightly different times
// - high-impedance bit set floats the output driver; resets clear
// - drain bit set makes output pull low only; resets clear
// - pull-up bit enables input pull-up; resets to all ones
// - a zero interrupt mask bit suppresses every interrupt from that pin
// - registers control a pin only while its function-select bit is one
`timescale 1ns/1ns
module gbipc_top
    import gbipc_pkg::*;
#(
    parameter int NPINS = GBIPC_NPINS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [31:0] pin_in_i,
    input wire logic [31:0] func_sel_i,
    input wire logic [15:0] dir_lo_i,
    input wire logic [15:0] pin_irq_mask_i,
    input wire logic [15:0] irq_clear_i,
    output logic [15:0] pad_out_o,
    output logic [15:0] pad_oe_n_o,
    output logic [15:0] pullup_en_o,
    output logic [15:0] irq_pending_o,
    output logic irq_o
);

    // refused at elaboration: the register map covers exactly two 16-pin halves
    if (NPINS != 2 * GBIPC_HALF) begin : g_npins_check
        $error("gbipc_top: NPINS must be 32");
    end

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    gbipc_edge_if #(.W(NPINS)) edges ();

    gbipc_edge_detect #(.W(NPINS)) u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_in_i),
        .edge_o(edges)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] rise_en_r;
    logic [15:0] fall_en_r;
    logic [15:0] dir_hi_r;
    logic [15:0] level_r;
    logic [15:0] hiz_r;
    logic [15:0] drain_r;
    logic [15:0] pullup_r;
    logic [15:0] pending_r;
    logic [15:0] pending_nxt;
    logic [15:0] sel_hi;
    logic [15:0] out_en_hi;
    logic [15:0] in_lo;
    logic [15:0] hit_lo;
    logic [15:0] wmask;
    logic [15:0] rd_nxt;
    logic wr_set;
    logic wr_clr;
    logic wr_lvl;

    assign sel_hi = func_sel_i[31:16];
    // only pins owned by this block and set as outputs take writes
    assign out_en_hi = dir_hi_r & sel_hi;
    assign wmask = reg_wdata_i & out_en_hi;
    assign wr_set = reg_wr_i && gbipc_hit(reg_addr_i, OFS_DRV_HIGH_HI);
    assign wr_clr = reg_wr_i && gbipc_hit(reg_addr_i, OFS_DRV_LOW_HI);
    assign wr_lvl = reg_wr_i && gbipc_hit(reg_addr_i, OFS_LEVEL_HI);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_en_r <= RST_RISE_EN;
            fall_en_r <= RST_FALL_EN;
        end else if (reg_wr_i) begin
            if (gbipc_hit(reg_addr_i, OFS_RISE_EN_LO)) begin
                rise_en_r <= reg_wdata_i;
            end
            if (gbipc_hit(reg_addr_i, OFS_FALL_EN_LO)) begin
                fall_en_r <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_hi_r <= RST_DIR;
            hiz_r <= RST_HIZ;
            drain_r <= RST_DRAIN;
            pullup_r <= RST_PULLUP;
        end else if (reg_wr_i) begin
            if (gbipc_hit(reg_addr_i, OFS_DIR_HI)) begin
                dir_hi_r <= reg_wdata_i;
            end
            if (gbipc_hit(reg_addr_i, OFS_HIZ_HI)) begin
                hiz_r <= reg_wdata_i;
            end
            if (gbipc_hit(reg_addr_i, OFS_DRAIN_HI)) begin
                drain_r <= reg_wdata_i;
            end
            // software is expected to pair this with direction changes;
            // hardware only drops the pad pull-up on pins set as outputs or not owned by this block
            if (gbipc_hit(reg_addr_i, OFS_PULLUP_HI)) begin
                pullup_r <= reg_wdata_i;
            end
        end
    end

    // output latch; only one register is written per cycle, so the three
    // write paths never collide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_r <= RST_LEVEL;
        end else if (wr_set) begin
            level_r <= level_r | wmask;
        end else if (wr_clr) begin
            level_r <= level_r & ~wmask;
        end else if (wr_lvl) begin
            level_r <= (level_r & ~out_en_hi) | wmask;
        end
    end

    // ------------------------------------------------------------
    // pad drivers
    // ------------------------------------------------------------
    // pads follow the latch one cycle later; all bits move on the same
    // edge here although the board may still see them staggered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_out_o <= '0;
            pad_oe_n_o <= '1;
            pullup_en_o <= '0;
        end else begin
            pad_out_o <= level_r & ~drain_r;
            // a drain pin is enabled only while pulling low
            pad_oe_n_o <= ~(out_en_hi & ~hiz_r & (~drain_r | ~level_r));
            pullup_en_o <= pullup_r & ~dir_hi_r & sel_hi;
        end
    end

    // ------------------------------------------------------------
    // edge interrupts, low bank
    // ------------------------------------------------------------
    assign in_lo = ~dir_lo_i & func_sel_i[15:0];
    assign hit_lo = ((edges.rise[15:0] & rise_en_r) | (edges.fall[15:0] & fall_en_r))
        & pin_irq_mask_i & in_lo;
    // a new edge in the clearing cycle wins over the clear
    assign pending_nxt = (pending_r & ~irq_clear_i) | hit_lo;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_r <= '0;
            irq_o <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
            irq_o <= |pending_nxt;
        end
    end

    assign irq_pending_o = pending_r;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = RD_NONE;
        case (reg_addr_i)
            OFS_RISE_EN_LO: rd_nxt = rise_en_r;
            OFS_FALL_EN_LO: rd_nxt = fall_en_r;
            OFS_DIR_HI: rd_nxt = dir_hi_r;
            OFS_LEVEL_HI: rd_nxt = edges.level[31:16] & sel_hi;
            OFS_HIZ_HI: rd_nxt = hiz_r;
            OFS_DRAIN_HI: rd_nxt = drain_r;
            OFS_PULLUP_HI: rd_nxt = pullup_r;
            default: rd_nxt = RD_NONE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= RD_NONE;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] rise_hit;
    logic [15:0] fall_hit;
    logic [15:0] both_hit;
    assign rise_hit = edges.rise[15:0] & rise_en_r & pin_irq_mask_i & in_lo;
    assign fall_hit = edges.fall[15:0] & fall_en_r & pin_irq_mask_i & in_lo;
    assign both_hit = (edges.rise[15:0] | edges.fall[15:0]) & rise_en_r & fall_en_r
        & pin_irq_mask_i & in_lo;

    sequence s_wr_set;
        reg_wr_i && gbipc_hit(reg_addr_i, OFS_DRV_HIGH_HI);
    endsequence
    sequence s_wr_clr;
        reg_wr_i && gbipc_hit(reg_addr_i, OFS_DRV_LOW_HI);
    endsequence
    sequence s_wr_lvl;
        reg_wr_i && gbipc_hit(reg_addr_i, OFS_LEVEL_HI);
    endsequence

    property p_rise_sets;
        @(posedge clk_i) disable iff (rst_i)
        (rise_hit != '0) |=> ((pending_r & $past(rise_hit)) == $past(rise_hit)) && irq_o;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("enabled rising edge did not set pending");

    property p_fall_sets;
        @(posedge clk_i) disable iff (rst_i)
        (fall_hit != '0) |=> ((pending_r & $past(fall_hit)) == $past(fall_hit)) && irq_o;
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("enabled falling edge did not set pending");

    property p_both_edges;
        @(posedge clk_i) disable iff (rst_i)
        (both_hit != '0) |=> ((pending_r & $past(both_hit)) == $past(both_hit));
    endproperty
    a_both_edges: assert property (p_both_edges)
        else $error("transition with both enables lost");

    property p_no_out_irq;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((pending_r & ~$past(pending_r) & ~$past(in_lo)) == '0);
    endproperty
    a_no_out_irq: assert property (p_no_out_irq)
        else $error("output or foreign pin set pending");

    property p_mask_gates;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((pending_r & ~$past(pending_r) & ~$past(pin_irq_mask_i)) == '0);
    endproperty
    a_mask_gates: assert property (p_mask_gates)
        else $error("masked pin set pending");

    property p_reset_vals;
        @(posedge clk_i)
        rst_i |=> (dir_hi_r == RST_DIR) && (pullup_r == RST_PULLUP)
            && (rise_en_r == RST_RISE_EN) && (hiz_r == RST_HIZ) && (drain_r == RST_DRAIN);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("register reset value wrong");

    property p_set_drives;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_set |=> ((level_r & $past(wmask)) == $past(wmask))
            ##1 ((pad_oe_n_o | pad_out_o | $past(drain_r)) & $past(wmask, 2)) == $past(wmask, 2);
    endproperty
    a_set_drives: assert property (p_set_drives)
        else $error("drive-high write did not raise pin");

    property p_clr_drives;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_clr |=> ((level_r & $past(wmask)) == '0) ##1 ((pad_out_o & $past(wmask, 2)) == '0);
    endproperty
    a_clr_drives: assert property (p_clr_drives)
        else $error("drive-low write did not lower pin");

    property p_lvl_inputs_kept;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_lvl |=> ((level_r ^ $past(level_r)) & ~$past(out_en_hi)) == '0;
    endproperty
    a_lvl_inputs_kept: assert property (p_lvl_inputs_kept)
        else $error("level write touched an input pin");

    property p_read_level;
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && gbipc_hit(reg_addr_i, OFS_LEVEL_HI))
            |=> reg_rvalid_o && (reg_rdata_o == ($past(edges.level[31:16]) & $past(sel_hi)));
    endproperty
    a_read_level: assert property (p_read_level)
        else $error("level read mismatch");

    property p_hiz_floats;
        @(posedge clk_i) disable iff (rst_i)
        ((hiz_r | ~out_en_hi) != '0) |=> ((~pad_oe_n_o & $past(hiz_r | ~out_en_hi)) == '0);
    endproperty
    a_hiz_floats: assert property (p_hiz_floats)
        else $error("floated or foreign pin is driven");

    property p_drain_high_released;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((~pad_oe_n_o & $past(drain_r & level_r)) == '0);
    endproperty
    a_drain_high_released: assert property (p_drain_high_released)
        else $error("drain pin actively driven high");

    property p_irq_line;
        @(posedge clk_i) disable iff (rst_i)
        ##1 (irq_o == (pending_r != '0));
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("request line disagrees with pending flags");

    property p_rvalid_once;
        @(posedge clk_i) disable iff (rst_i)
        ##1 (reg_rvalid_o == $past(reg_rd_i));
    endproperty
    a_rvalid_once: assert property (p_rvalid_once)
        else $error("read answer not exactly one cycle after the strobe");

    property p_pullup_inputs_only;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (pullup_en_o & $past(dir_hi_r | ~sel_hi)) == '0;
    endproperty
    a_pullup_inputs_only: assert property (p_pullup_inputs_only)
        else $error("pull-up enabled on an output or foreign pin");

endmodule // gbipc_top

/* File: sim/gbipc_periph_model.sv */
// peripherals wired to the pin bank: resolves every pad wire level
// assumes the bench says per pin whether a peripheral drives it and to what value
`timescale 1ns/1ns
module gbipc_periph_model (
    input wire logic clk_i,
    input wire logic [15:0] pad_out_i,
    input wire logic [15:0] pad_oe_n_i,
    input wire logic [15:0] pullup_en_i,
    input wire logic [31:0] ext_val_i,
    input wire logic [31:0] ext_en_i,
    output logic [31:0] pin_o
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    logic [31:0] float_r;
    logic [31:0] wire_lvl;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            // the low bank is always driven by a peripheral in this bench
            wire_lvl[i] = ext_en_i[i] ? ext_val_i[i] : float_r[i];
        end
        for (int i = 0; i < 16; i++) begin
            if (pad_oe_n_i[i] == 1'b0) begin
                wire_lvl[16+i] = pad_out_i[i];
            end else if (ext_en_i[16+i]) begin
                wire_lvl[16+i] = ext_val_i[16+i];
            end else if (pullup_en_i[i]) begin
                wire_lvl[16+i] = 1'b1;
            end else begin
                // a floating pad must not read back a stable value
                wire_lvl[16+i] = float_r[16+i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        float_r <= ~wire_lvl;
    end

    assign pin_o = wire_lvl;
endmodule // gbipc_periph_model

/* File: sim/testbench.sv */
// self-checking bench for the pin bank controller
// assumes the package constants and a peripheral model on every pad
`timescale 1ns/1ns
module testbench
    import gbipc_pkg::*;
();
    logic clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, irq_o;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, dir_lo_i, pin_irq_mask_i, irq_clear_i;
    logic [15:0] pad_out_o, pad_oe_n_o, pullup_en_o, irq_pending_o;
    logic [31:0] pin_in_i, func_sel_i, ext_val, ext_en;
    int n_fail = 0;
    int n_compared = 0;
    // order: rise, fall, dir, drive high, drive low, level, hiz, drain, pullup, unmapped
    logic [15:0] r_addr [10] = '{OFS_RISE_EN_LO, OFS_FALL_EN_LO, OFS_DIR_HI, OFS_DRV_HIGH_HI,
        OFS_DRV_LOW_HI, OFS_LEVEL_HI, OFS_HIZ_HI, OFS_DRAIN_HI, OFS_PULLUP_HI, 16'h03cc};
    logic [15:0] r_exp [10] = '{RST_RISE_EN, RST_FALL_EN, RST_DIR, RD_NONE, RD_NONE,
        16'hffff, RST_HIZ, RST_DRAIN, RST_PULLUP, RD_NONE};
    int rw_idx [6] = '{0, 1, 2, 6, 7, 8};
    int e_pin [10] = '{0, 0, 1, 1, 2, 2, 3, 4, 5, 6};
    logic e_val [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [15:0] e_exp [10] = '{16'h0001, 16'h0000, 16'h0000, 16'h0002, 16'h0004,
        16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    gbipc_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .pin_in_i(pin_in_i), .func_sel_i(func_sel_i),
        .dir_lo_i(dir_lo_i), .pin_irq_mask_i(pin_irq_mask_i), .irq_clear_i(irq_clear_i),
        .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .pullup_en_o(pullup_en_o),
        .irq_pending_o(irq_pending_o), .irq_o(irq_o)
    );

    gbipc_periph_model periph (
        .clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pullup_en_i(pullup_en_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pin_in_i)
    );

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    // inputs always change 10 ns after the rising edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #10;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        wait_cyc(1);
        reg_wr_i = 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] a, input logic [15:0] exp, input string nm);
        int k = 0;
        @(posedge clk_i);
        #10;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        wait_cyc(1);
        reg_rd_i = 1'b0;
        while (reg_rvalid_o !== 1'b1 && k < 4) begin
            wait_cyc(1);
            k++;
        end
        if (k >= 4) begin
            $display("[ERR] %s expected %h seen %h", "read answer", 1'b1, reg_rvalid_o);
            n_fail++;
            complete_run();
        end
        chk(nm, exp, reg_rdata_o);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        {reg_wr_i, reg_rd_i} = 2'b00;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 16'h0000;
        func_sel_i = 32'hffff_ffff;
        dir_lo_i = 16'h0000;
        pin_irq_mask_i = 16'hffff;
        irq_clear_i = 16'h0000;
        ext_val = 32'h0000_0000;
        ext_en = 32'h0000_ffff;
        repeat (12) @(posedge clk_i);
        #10;
        rst_i = 1'b0;
        wait_cyc(5);

        chk("pad enables", 16'hffff, pad_oe_n_o);
        chk("pullups", 16'hffff, pullup_en_o);
        chk("interrupt line", 16'h0000, {15'h0000, irq_o});
        for (int i = 0; i < 10; i++) begin
            reg_read(r_addr[i], r_exp[i], "reset value");
        end
        for (int i = 0; i < 6; i++) begin
            reg_write(r_addr[rw_idx[i]], 16'h5a3c);
            reg_read(r_addr[rw_idx[i]], 16'h5a3c, "read back");
            reg_write(r_addr[rw_idx[i]], r_exp[rw_idx[i]]);
        end
        $display("test registers done");

        reg_write(OFS_PULLUP_HI, 16'hff00);
        reg_write(OFS_DIR_HI, 16'h00ff);
        reg_write(OFS_DRV_HIGH_HI, 16'h0f0f);
        wait_cyc(4);
        chk("pad out set", 16'h000f, pad_out_o);
        chk("pad enables", 16'hff00, pad_oe_n_o);
        chk("pullups", 16'hff00, pullup_en_o);
        reg_read(OFS_LEVEL_HI, 16'hff0f, "level");
        reg_write(OFS_DRV_LOW_HI, 16'h0003);
        wait_cyc(4);
        chk("pad out clear", 16'h000c, pad_out_o);
        reg_write(OFS_LEVEL_HI, 16'haaaa);
        wait_cyc(4);
        chk("pad out level", 16'h00aa, pad_out_o);
        reg_read(OFS_LEVEL_HI, 16'hffaa, "level");
        $display("test drive done");

        reg_write(OFS_HIZ_HI, 16'h0001);
        reg_write(OFS_DRAIN_HI, 16'h0006);
        wait_cyc(2);
        ext_val[17:16] = 2'b11;
        ext_en[17:16] = 2'b11;
        wait_cyc(4);
        chk("pad enables", 16'hff03, pad_oe_n_o);
        chk("drain low", 16'h0000, pad_out_o & 16'h0004);
        reg_read(OFS_LEVEL_HI, 16'hffab, "level");
        func_sel_i[23] = 1'b0;
        wait_cyc(4);
        chk("pad enables", 16'hff83, pad_oe_n_o);
        reg_read(OFS_LEVEL_HI, 16'hff2b, "level");
        func_sel_i[23] = 1'b1;
        $display("test pad modes done");

        // bit 4 masked, bit 5 an output, bit 6 not owned, bit 3 no enables
        dir_lo_i = 16'h0020;
        pin_irq_mask_i = 16'hffef;
        func_sel_i[6] = 1'b0;
        reg_write(OFS_RISE_EN_LO, 16'h0075);
        reg_write(OFS_FALL_EN_LO, 16'h0076);
        wait_cyc(2);
        for (int i = 0; i < 10; i++) begin
            ext_val[e_pin[i]] = e_val[i];
            wait_cyc(5);
            chk("pending", e_exp[i], irq_pending_o);
            chk("interrupt line", {15'h0000, |e_exp[i]}, {15'h0000, irq_o});
            irq_clear_i = 16'hffff;
            wait_cyc(1);
            irq_clear_i = 16'h0000;
            wait_cyc(3);
            chk("pending cleared", 16'h0000, irq_pending_o);
        end
        $display("test edges done");
        complete_run();
    end
endmodule // testbench
